// >>> shared/oslpm_defines.svh
// Register map, field positions, reset values, vectors and delays of the oscillator/low-power block.
// Assumes a 32-bit APB bus and 25 MHz clk; included by bare name.
`ifndef OSLPM_DEFINES_SVH
`define OSLPM_DEFINES_SVH
`define OSLPM_CLK_MHZ       25
`define OSLPM_ADDR_CTRL     8'h00
`define OSLPM_ADDR_OPT      8'h04
`define OSLPM_ADDR_CTMR     8'h08
`define OSLPM_ADDR_PTMR     8'h0c
`define OSLPM_ADDR_STAT     8'h10
`define OSLPM_CTRL_EE       7
`define OSLPM_CTRL_FLAG     6
`define OSLPM_CTRL_ACK      5
`define OSLPM_CTRL_OSC_HI   1
`define OSLPM_CTRL_OSC_LO   0
`define OSLPM_OSC_RESET     2'b10
`define OSLPM_OSC_EXT_ONLY  2'b01
`define OSLPM_OPT_DELAY     0
`define OSLPM_OPT_PORT      1
`define OSLPM_OPT_HALT      2
`define OSLPM_CT_OVF_F      7
`define OSLPM_CT_PER_F      6
`define OSLPM_CT_OVF_E      5
`define OSLPM_CT_PER_E      4
`define OSLPM_PT_CAP_F      7
`define OSLPM_PT_CMP_F      6
`define OSLPM_PT_OVF_F      5
`define OSLPM_PT_CAP_E      2
`define OSLPM_PT_CMP_E      1
`define OSLPM_PT_OVF_E      0
`define OSLPM_VEC_RESET     16'h1ffe
`define OSLPM_VEC_EXT       16'h1ffa
`define OSLPM_VEC_CTMR      16'h1ff8
`define OSLPM_VEC_PTMR      16'h1ff6
`define OSLPM_VEC_SER       16'h1ff4
`define OSLPM_VEC_ANA       16'h1ff2
`define OSLPM_DLY_SHORT     12'h010
`define OSLPM_DLY_LONG      12'hfe0
`endif

// >>> shared/oslpm_pkg.sv
// Types shared by the oscillator/low-power block.
// Assumes nothing beyond the defines header.
package oslpm_pkg;
	typedef enum logic [2:0] {
		OSLPM_RUN,
		OSLPM_STOP,
		OSLPM_WAIT,
		OSLPM_HALT,
		OSLPM_RECOV
	} oslpm_mode_e;
endpackage : oslpm_pkg

// >>> verilog/oslpm_top.sv
// Oscillator select and stop/wait/halt control with APB register access.
// Assumes all inputs synchronous to clk; mode requests and events are one-cycle pulses.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "oslpm_defines.svh"

// Contract
// - Select bits choose internal, external or both oscillators.
// - Reset selects internal, external oscillator off.
// - Flag set on request; ack write clears it.
// - Enable bit read/write, gates external requests.
// - Stop halts oscillators and clocks, keeps selection.
// - Stop clears core timer flags and enables.
// - Stop clears programmable timer flags and enables.
// - Stop sets external enable, clears global mask.
// - External falling edge wakes, vector 1FFA.
// - Port rising edge wakes when option set.
// - Reset pin low ends mode, vector 1FFE.
// - Stop exit waits 16 or 4064 cycles.
// - Wait unmasks, enables external, stops core clock.
// - Core timer interrupt wakes wait, vector 1FF8.
// - Programmable timer interrupt wakes wait, vector 1FF6.
// - Serial transfer done wakes wait, vector 1FF4.
// - Comparator interrupt wakes wait, vector 1FF2.
// - Watchdog timeout in wait resets, reset vector.
// - Wait exit resumes without delay.
// - Halt acts as wait, variable recovery delay.
module oslpm_top (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   stop_req,
	input  wire logic                   wait_req,
	input  wire logic                   ext_int_n,
	input  wire logic [3:0]             port_a_low_pins,
	input  wire logic                   reset_pin_n,
	input  wire logic                   core_tmr_evt,
	input  wire logic                   periodic_evt,
	input  wire logic                   capture_evt,
	input  wire logic                   compare_evt,
	input  wire logic                   ptmr_ovf_evt,
	input  wire logic                   serial_done_evt,
	input  wire logic                   analog_evt,
	input  wire logic                   watchdog_timeout,
	output logic                        lpo_enable,
	output logic                        epo_enable,
	output logic                        core_clk_ext_sel,
	output logic                        cpu_clk_run,
	output logic                        periph_clk_run,
	output logic                        watchdog_run,
	output logic                        int_unmask,
	output logic                        wake,
	output logic      [15:0]            vector,
	output logic                        core_reset,
	output oslpm_pkg::oslpm_mode_e      mode
);
	import oslpm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic               ee_ff, flag_ff, delay_ff, port_ff, halt_ff;
	logic [1:0]         osc_ff;
	logic [3:0]         ct_ff;
	logic [5:0]         pt_ff;
	logic               ext_prev_ff;
	logic [3:0]         pa_prev_ff;
	logic [11:0]        free_ff, cnt_ff;
	logic [15:0]        vec_ff;
	oslpm_mode_e        mode_ff;
	logic               wake_ff, unmask_ff, corerst_ff;
	logic               lpo_ff, epo_ff, extsel_ff, cpu_ff, peri_ff, wdt_ff;
	logic               pready_ff, pslverr_ff;
	logic [31:0]        prdata_ff;
	logic               dev_rst, acc, wr, ext_evt, ct_irq, pt_irq, any_wake;
	logic               enter_stop, enter_low;
	logic [11:0]        var_dly;
	logic [15:0]        wake_vec;
	logic [31:0]        rd_val;
	logic               rd_ok;

	// Watchdog only counts while its clock runs, so a timeout in stop cannot occur
	assign dev_rst    = rst | ~reset_pin_n | (watchdog_timeout & wdt_ff);
	assign acc        = psel & penable & pready_ff;
	assign wr         = acc & pwrite;
	assign ext_evt    = ee_ff & ((ext_prev_ff & ~ext_int_n)
	                    | (port_ff & |(port_a_low_pins & ~pa_prev_ff)));
	assign ct_irq     = (ct_ff[3] & ct_ff[1]) | (ct_ff[2] & ct_ff[0]);
	assign pt_irq     = |(pt_ff[5:3] & pt_ff[2:0]);
	assign enter_stop = (mode_ff == OSLPM_RUN) & stop_req & ~halt_ff;
	assign enter_low  = (mode_ff == OSLPM_RUN) & (stop_req | wait_req);

	////////////////////////////////////////////////////////////////////////
	// Interrupt/oscillator control register
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			ee_ff   <= 1'b1;
			osc_ff  <= `OSLPM_OSC_RESET;
			flag_ff <= 1'b0;
		end else begin
			if (wr && paddr == `OSLPM_ADDR_CTRL) begin
				ee_ff  <= pwdata[`OSLPM_CTRL_EE];
				osc_ff <= pwdata[`OSLPM_CTRL_OSC_HI:`OSLPM_CTRL_OSC_LO];
			end
			if (enter_low)
				ee_ff <= 1'b1;
			// A new request in the ack cycle is kept
			if (ext_evt)
				flag_ff <= 1'b1;
			else if (wr && paddr == `OSLPM_ADDR_CTRL && pwdata[`OSLPM_CTRL_ACK])
				flag_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Option word
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			delay_ff <= 1'b0;
			port_ff  <= 1'b0;
			halt_ff  <= 1'b0;
		end else if (wr && paddr == `OSLPM_ADDR_OPT) begin
			delay_ff <= pwdata[`OSLPM_OPT_DELAY];
			port_ff  <= pwdata[`OSLPM_OPT_PORT];
			halt_ff  <= pwdata[`OSLPM_OPT_HALT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer flag/enable images; flags are write-one-to-clear, set wins
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			ct_ff <= 4'h0;
			pt_ff <= 6'h00;
		end else if (enter_stop) begin
			ct_ff <= 4'h0;
			pt_ff <= 6'h00;
		end else begin
			if (wr && paddr == `OSLPM_ADDR_CTMR) begin
				ct_ff[1:0] <= pwdata[`OSLPM_CT_OVF_E:`OSLPM_CT_PER_E];
				ct_ff[3:2] <= ct_ff[3:2] & ~pwdata[`OSLPM_CT_OVF_F:`OSLPM_CT_PER_F];
			end
			if (wr && paddr == `OSLPM_ADDR_PTMR) begin
				pt_ff[2:0] <= pwdata[`OSLPM_PT_CAP_E:`OSLPM_PT_OVF_E];
				pt_ff[5:3] <= pt_ff[5:3] & ~pwdata[`OSLPM_PT_CAP_F:`OSLPM_PT_OVF_F];
			end
			// Stopped clocks mean no timer events in stop
			if (mode_ff != OSLPM_STOP) begin
				if (core_tmr_evt) ct_ff[3] <= 1'b1;
				if (periodic_evt) ct_ff[2] <= 1'b1;
				if (capture_evt)  pt_ff[5] <= 1'b1;
				if (compare_evt)  pt_ff[4] <= 1'b1;
				if (ptmr_ovf_evt) pt_ff[3] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin history and free-running counter for the halt recovery spread
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_prev_ff <= 1'b1;
			pa_prev_ff  <= 4'h0;
			free_ff     <= 12'h000;
		end else begin
			ext_prev_ff <= ext_int_n;
			pa_prev_ff  <= port_a_low_pins;
			free_ff     <= free_ff + 12'h001;
		end
	end

	always_comb begin
		if (delay_ff)
			var_dly = (free_ff >= `OSLPM_DLY_LONG) ? `OSLPM_DLY_LONG : free_ff + 12'h001;
		else
			var_dly = {8'h00, free_ff[3:0]} + 12'h001;
		// External request outranks the peripherals
		any_wake = 1'b1;
		if (ext_evt)              wake_vec = `OSLPM_VEC_EXT;
		else if (ct_irq)          wake_vec = `OSLPM_VEC_CTMR;
		else if (pt_irq)          wake_vec = `OSLPM_VEC_PTMR;
		else if (serial_done_evt) wake_vec = `OSLPM_VEC_SER;
		else if (analog_evt)      wake_vec = `OSLPM_VEC_ANA;
		else begin
			wake_vec = vec_ff;
			any_wake = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode sequencer
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			mode_ff    <= OSLPM_RUN;
			cnt_ff     <= 12'h000;
			vec_ff     <= `OSLPM_VEC_RESET;
			wake_ff    <= 1'b0;
			unmask_ff  <= 1'b0;
			corerst_ff <= 1'b1;
		end else begin
			wake_ff    <= 1'b0;
			unmask_ff  <= 1'b0;
			corerst_ff <= 1'b0;
			case (mode_ff)
				OSLPM_RUN: begin
					if (stop_req) begin
						mode_ff   <= halt_ff ? OSLPM_HALT : OSLPM_STOP;
						unmask_ff <= 1'b1;
					end else if (wait_req) begin
						mode_ff   <= OSLPM_WAIT;
						unmask_ff <= 1'b1;
					end
				end
				OSLPM_STOP: begin
					if (ext_evt) begin
						vec_ff  <= `OSLPM_VEC_EXT;
						cnt_ff  <= delay_ff ? `OSLPM_DLY_LONG : `OSLPM_DLY_SHORT;
						mode_ff <= OSLPM_RECOV;
					end
				end
				OSLPM_WAIT: begin
					if (any_wake) begin
						vec_ff  <= wake_vec;
						wake_ff <= 1'b1;
						mode_ff <= OSLPM_RUN;
					end
				end
				OSLPM_HALT: begin
					if (any_wake) begin
						vec_ff  <= wake_vec;
						cnt_ff  <= var_dly;
						mode_ff <= OSLPM_RECOV;
					end
				end
				OSLPM_RECOV: begin
					cnt_ff <= cnt_ff - 12'h001;
					if (cnt_ff <= 12'h001) begin
						wake_ff <= 1'b1;
						mode_ff <= OSLPM_RUN;
					end
				end
				default: mode_ff <= OSLPM_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock gating outputs
	always_ff @(posedge clk) begin
		if (dev_rst) begin
			lpo_ff    <= 1'b1;
			epo_ff    <= 1'b0;
			extsel_ff <= 1'b0;
			cpu_ff    <= 1'b0;
			peri_ff   <= 1'b1;
			wdt_ff    <= 1'b1;
		end else begin
			lpo_ff    <= (mode_ff != OSLPM_STOP) && (osc_ff != `OSLPM_OSC_EXT_ONLY);
			epo_ff    <= (mode_ff != OSLPM_STOP) && osc_ff[0];
			extsel_ff <= (osc_ff == `OSLPM_OSC_EXT_ONLY);
			cpu_ff    <= (mode_ff == OSLPM_RUN);
			peri_ff   <= (mode_ff != OSLPM_STOP);
			wdt_ff    <= (mode_ff != OSLPM_STOP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, unmapped reads zero with an error
	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`OSLPM_ADDR_CTRL: rd_val = {24'h000000, ee_ff, flag_ff, 4'h0, osc_ff};
			`OSLPM_ADDR_OPT:  rd_val = {29'h00000000, halt_ff, port_ff, delay_ff};
			`OSLPM_ADDR_CTMR: rd_val = {24'h000000, ct_ff, 4'h0};
			`OSLPM_ADDR_PTMR: rd_val = {24'h000000, pt_ff[5:3], 2'b00, pt_ff[2:0]};
			`OSLPM_ADDR_STAT: rd_val = {vec_ff, 13'h0000, mode_ff};
			default:          rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= psel & penable & ~pready_ff & ~rd_ok;
			prdata_ff  <= (psel & ~pwrite) ? rd_val : 32'h0000_0000;
		end
	end

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign lpo_enable       = lpo_ff;
	assign epo_enable       = epo_ff;
	assign core_clk_ext_sel = extsel_ff;
	assign cpu_clk_run      = cpu_ff;
	assign periph_clk_run   = peri_ff;
	assign watchdog_run     = wdt_ff;
	assign int_unmask       = unmask_ff;
	assign wake             = wake_ff;
	assign vector           = vec_ff;
	assign core_reset       = corerst_ff;
	assign mode             = mode_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (dev_rst);

	sequence s_stop_wake_short;
		mode_ff == OSLPM_STOP && ext_evt && !delay_ff;
	endsequence
	sequence s_wait_wake;
		mode_ff == OSLPM_WAIT && any_wake;
	endsequence

	property p_osc_map;
		(mode_ff == OSLPM_RUN) && $stable(osc_ff) |=> lpo_ff == ($past(osc_ff) != 2'b01) && epo_ff == $past(osc_ff[0]);
	endproperty
	a_osc_map: assert property (p_osc_map) else $error("oscillator enables wrong");
	property p_reset_osc;
		disable iff (1'b0) rst |=> osc_ff == 2'b10 && !epo_ff;
	endproperty
	a_reset_osc: assert property (p_reset_osc) else $error("reset oscillator selection wrong");
	property p_ack;
		wr && paddr == `OSLPM_ADDR_CTRL && pwdata[`OSLPM_CTRL_ACK] && !ext_evt |=> !flag_ff;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear flag");
	property p_gate;
		!ee_ff && !flag_ff && !(wr && paddr == `OSLPM_ADDR_CTRL) |=> !flag_ff;
	endproperty
	a_gate: assert property (p_gate) else $error("flag set while disabled");
	property p_stop_clear;
		enter_stop |=> ct_ff == 4'h0 && pt_ff == 6'h00 && ee_ff && unmask_ff ##1 !lpo_ff && !epo_ff;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop entry effects wrong");
	property p_stop_delay;
		s_stop_wake_short |=> !wake_ff [*8] ##1 !wake_ff [*8] ##1 wake_ff && mode_ff == OSLPM_RUN;
	endproperty
	a_stop_delay: assert property (p_stop_delay) else $error("stop recovery not 16 cycles");
	property p_wait_fast;
		s_wait_wake |=> wake_ff && vec_ff == $past(wake_vec);
	endproperty
	a_wait_fast: assert property (p_wait_fast) else $error("wait exit delayed");
	property p_ct_vec;
		s_wait_wake ##0 !ext_evt && ct_irq |=> vec_ff == 16'h1ff8;
	endproperty
	a_ct_vec: assert property (p_ct_vec) else $error("core timer vector wrong");
	property p_pt_vec;
		s_wait_wake ##0 !ext_evt && !ct_irq && pt_irq |=> vec_ff == 16'h1ff6;
	endproperty
	a_pt_vec: assert property (p_pt_vec) else $error("programmable timer vector wrong");
	property p_ser_vec;
		s_wait_wake ##0 !ext_evt && !ct_irq && !pt_irq && serial_done_evt |=> vec_ff == 16'h1ff4;
	endproperty
	a_ser_vec: assert property (p_ser_vec) else $error("serial vector wrong");
	property p_ana_vec;
		s_wait_wake ##0 !ext_evt && !ct_irq && !pt_irq && !serial_done_evt && analog_evt |=> vec_ff == 16'h1ff2;
	endproperty
	a_ana_vec: assert property (p_ana_vec) else $error("comparator vector wrong");
	property p_pin_reset;
		disable iff (rst) !reset_pin_n |=> vec_ff == 16'h1ffe && mode_ff == OSLPM_RUN && core_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("reset pin not honoured");
	property p_halt_bound;
		mode_ff == OSLPM_HALT && any_wake && !delay_ff |=> ##[1:16] wake_ff;
	endproperty
	a_halt_bound: assert property (p_halt_bound) else $error("halt recovery out of range");
endmodule : oslpm_top

// >>> verification/oslpm_pin_drv.sv
// Pin-side partner: drives the external interrupt pin, the port A low pins and the reset pin.
// Assumes bench requests are launched just after clk edges; pins are pulled to their idle level.
`timescale 1ns/10ps
module oslpm_pin_drv (
	input  wire logic       clk,
	input  wire logic       fall_req,
	input  wire logic [3:0] rise_req,
	input  wire logic       hold_low,
	output logic            ext_int_n = 1'b1,
	output logic [3:0]      port_a_low_pins = 4'h0,
	output logic            reset_pin_n = 1'b1
);
	logic       fall_d_ff = 1'b0;
	logic [3:0] rise_d_ff = 4'h0;
	////////////////////////////////////////////////////////////////
	// Pulses stretched to two edges so a sampling edge detector cannot miss them
	always @(posedge clk) begin
		fall_d_ff <= fall_req;
		ext_int_n <= ~(fall_req | fall_d_ff);
	end
	always @(posedge clk) begin
		rise_d_ff       <= rise_req;
		port_a_low_pins <= rise_req | rise_d_ff;
	end
	// Reset stays low for the whole retention span and is released only afterwards
	always @(posedge clk) begin
		reset_pin_n <= ~hold_low;
	end
endmodule : oslpm_pin_drv

// >>> verification/oscillator_select_low_power_modes_bench.sv
// Self-checking bench for the oscillator select and low-power mode block.
// Assumes the pin partner model and the block's one-wait-state APB slave.
`timescale 1ns/10ps
`include "oslpm_defines.svh"
module oscillator_select_low_power_modes_bench;
	import oslpm_pkg::*;
	logic        clk, rst, psel, penable, pwrite, stop_req, wait_req, hold_low, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, lpo_enable, epo_enable, core_clk_ext_sel, cpu_clk_run;
	logic        periph_clk_run, watchdog_run, int_unmask, wake, core_reset, ext_int_n, reset_pin_n;
	logic [15:0] vector;
	logic [8:0]  ev;
	logic [3:0]  rise_req, port_a_low_pins;
	oslpm_mode_e mode;
	int          mismatches, tests_run, n, unm;
	logic [1:0]  osc_seq [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
	int          src [8] = '{0, 1, 2, 3, 4, 5, 6, 8};
	logic [15:0] vec [8] = '{16'h1ff8, 16'h1ff8, 16'h1ff6, 16'h1ff6, 16'h1ff6, 16'h1ff4, 16'h1ff2, 16'h1ffa};
	oslpm_top u_oslpm_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stop_req(stop_req), .wait_req(wait_req), .ext_int_n(ext_int_n), .port_a_low_pins(port_a_low_pins),
		.reset_pin_n(reset_pin_n), .core_tmr_evt(ev[0]), .periodic_evt(ev[1]), .capture_evt(ev[2]),
		.compare_evt(ev[3]), .ptmr_ovf_evt(ev[4]), .serial_done_evt(ev[5]), .analog_evt(ev[6]),
		.watchdog_timeout(ev[7]), .lpo_enable(lpo_enable), .epo_enable(epo_enable),
		.core_clk_ext_sel(core_clk_ext_sel), .cpu_clk_run(cpu_clk_run), .periph_clk_run(periph_clk_run),
		.watchdog_run(watchdog_run), .int_unmask(int_unmask), .wake(wake), .vector(vector),
		.core_reset(core_reset), .mode(mode));
	oslpm_pin_drv u_oslpm_pin_drv (.clk(clk), .fall_req(ev[8]), .rise_req(rise_req), .hold_low(hold_low),
		.ext_int_n(ext_int_n), .port_a_low_pins(port_a_low_pins), .reset_pin_n(reset_pin_n));
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (int_unmask === 1'b1) unm++;
	end
	function automatic logic [2:0] exp_osc(input logic [1:0] s);
		case (s)
			2'b01: exp_osc = 3'b011;
			2'b11: exp_osc = 3'b110;
			default: exp_osc = 3'b100;
		endcase
	endfunction : exp_osc
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc
	// Request held until pready is sampled high; an idle cycle follows so no signal is set twice
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		@(posedge clk);
	endtask : pulse
	task automatic req(input logic is_stop);
		if (is_stop) stop_req <= 1'b1;
		else wait_req <= 1'b1;
		@(posedge clk);
		stop_req <= 1'b0;
		wait_req <= 1'b0;
		cyc(3);
	endtask : req
	// Window is counted from the first edge after the task is called
	task automatic wake_wait(input int lo, input int hi, input logic [15:0] v);
		n = 0;
		do begin
			@(posedge clk);
			ev <= '0;
			n++;
		end while (wake !== 1'b1 && n < 5000);
		chk("wake latency in window", 32'(n >= lo && n <= hi), 1);
		chk("vector", vector, v);
		cyc(2);
	endtask : wake_wait
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		#(40 * 20000);
		mismatches++;
		conclude;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic b;
		int   r;
		rst = 1'b1;
		{psel, penable, pwrite, stop_req, wait_req, hold_low} = '0;
		{paddr, pwdata, ev, rise_req, mismatches, tests_run, unm} = '0;
		void'($urandom(32'h91ed3571));
		cyc(5);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, `OSLPM_ADDR_CTRL, 0);
		chk("ctrl reset", rd, 32'h82);
		chk("osc outputs", {lpo_enable, epo_enable, core_clk_ext_sel}, exp_osc(2'b10));
		apb(0, `OSLPM_ADDR_STAT, 0);
		chk("status reset", rd, 32'h1ffe0000);
		// Both-on step comes before external-only so the external oscillator settles first
		for (int i = 0; i < 4; i++) begin
			apb(1, `OSLPM_ADDR_CTRL, {24'h0, 6'h20, osc_seq[i]});
			cyc(2);
			chk("osc outputs", {lpo_enable, epo_enable, core_clk_ext_sel}, exp_osc(osc_seq[i]));
		end
		apb(0, 8'h24, 0);
		chk("unmapped error", err, 1);
		chk("unmapped data", rd, 0);
		for (int i = 0; i < 4; i++) begin
			b = 1'($urandom % 2);
			apb(1, `OSLPM_ADDR_CTRL, {24'h0, b, 7'h22});
			apb(0, `OSLPM_ADDR_CTRL, 0);
			chk("enable readback", rd, {24'h0, b, 7'h02});
			pulse(8);
			cyc(3);
			apb(0, `OSLPM_ADDR_CTRL, 0);
			chk("flag gated", rd[6], b);
		end
		apb(1, `OSLPM_ADDR_CTRL, 32'h22);
		apb(0, `OSLPM_ADDR_CTRL, 0);
		chk("ack clears flag", rd, 32'h02);
		apb(1, `OSLPM_ADDR_CTMR, 32'h30);
		pulse(0);
		pulse(1);
		apb(1, `OSLPM_ADDR_PTMR, 32'h07);
		pulse(2);
		n = unm;
		req(1);
		chk("mode", mode, OSLPM_STOP);
		chk("clocks", {cpu_clk_run, periph_clk_run, watchdog_run, lpo_enable, epo_enable}, 0);
		chk("unmask pulse", unm - n, 1);
		apb(0, `OSLPM_ADDR_CTRL, 0);
		chk("ctrl in stop", rd, 32'h82);
		apb(0, `OSLPM_ADDR_CTMR, 0);
		chk("core timer cleared", rd, 0);
		apb(0, `OSLPM_ADDR_PTMR, 0);
		chk("prog timer cleared", rd, 0);
		pulse(8);
		wake_wait(17, 22, `OSLPM_VEC_EXT);
		apb(1, `OSLPM_ADDR_OPT, 32'h3);
		req(1);
		rise_req <= 4'h1 << ($urandom % 4);
		@(posedge clk);
		rise_req <= 4'h0;
		wake_wait(4065, 4070, `OSLPM_VEC_EXT);
		apb(1, `OSLPM_ADDR_OPT, 0);
		r = $urandom % 8;
		for (int i = 0; i < 8; i++) begin
			apb(1, `OSLPM_ADDR_CTMR, 32'hf0);
			apb(1, `OSLPM_ADDR_PTMR, 32'he7);
			apb(1, `OSLPM_ADDR_CTRL, 32'ha2);
			n = unm;
			req(0);
			chk("mode", mode, OSLPM_WAIT);
			chk("clocks", {cpu_clk_run, periph_clk_run, watchdog_run, 1'(unm - n)}, 4'h7);
			ev[src[(i + r) % 8]] <= 1'b1;
			wake_wait(1, 3, vec[(i + r) % 8]);
		end
		// Leftover timer flags would wake halt at once, so their enables go off first
		apb(1, `OSLPM_ADDR_CTMR, 32'h00);
		apb(1, `OSLPM_ADDR_PTMR, 32'h00);
		apb(1, `OSLPM_ADDR_OPT, 32'h4);
		req(1);
		chk("halt state", {mode, watchdog_run, periph_clk_run}, {OSLPM_HALT, 2'b11});
		pulse(8);
		wake_wait(2, 22, `OSLPM_VEC_EXT);
		req(0);
		pulse(7);
		cyc(3);
		chk("watchdog vector", vector, `OSLPM_VEC_RESET);
		apb(0, `OSLPM_ADDR_OPT, 0);
		chk("option after reset", rd, 0);
		req(1);
		hold_low <= 1'b1;
		cyc(10);
		chk("core reset held", {core_reset, mode}, {1'b1, OSLPM_RUN});
		hold_low <= 1'b0;
		cyc(4);
		chk("reset pin vector", vector, `OSLPM_VEC_RESET);
		conclude;
	end
endmodule : oscillator_select_low_power_modes_bench
